// [core/gmii_pcs_bridge_cfg.svh]
`ifndef GMII_PCS_BRIDGE_CFG_SVH
`define GMII_PCS_BRIDGE_CFG_SVH

// =========================================================
// elastic buffer geometry and watermarks
`define EB_DEPTH     64
`define EB_WIDTH     10
`define EB_MARGIN    4
`define EB_HI_MARK   (`EB_DEPTH / 2 + `EB_MARGIN)
`define EB_LO_MARK   (`EB_DEPTH / 2 - `EB_MARGIN)

// =========================================================
// transmit word fields: {er, en, data[7:0]}
`define TXW_ER       9
`define TXW_EN       8
`define TXW_IDLE     10'h000
`define MTXW_IDLE    6'h00
`define RXD_RST      8'h00

`endif

// [core/gmii_pcs_bridge_pkg.sv]
package gmii_pcs_bridge_pkg;
  typedef logic [9:0] tx_word_t;
  typedef enum logic {
    SPD_MII,
    SPD_GMII
  } speed_mode_t;
endpackage : gmii_pcs_bridge_pkg

// [core/gmii_pcs_elastic_bridge.sv]
// Overview of operation
// R1 - all mac transmit data crosses the buffer
// R2 - mii receive nibble duplicated to both halves
// R3 - receive port mux chosen by link speed
// R4 - gigabit transmit crosses clocks through buffer
// R5 - mii mac transmit clock gated from pcs
// R6 - mac receive clock gated from pcs; gigabit mode toggles it on every pcs clock instead
// R7 - link speed picks transmit clock source
// R8 - only speed bit one, two-flop synchronised
// R9 - asynchronous fifo, sixty-four entries deep
// R10 - at high mark, write-side idles dropped
// R11 - at low mark, read idles repeated
// R12 - idle means enable and error zero
// R13 - soft reset input disables the buffer
// R14 - software holds soft reset across speed change
// R15 - zero-wait configuration access, no bursts
// R16 - reset release synchronised per clock domain
// R17 - soft reset clears pointers, sends idle
`timescale 1ns/1ns
`include "gmii_pcs_bridge_cfg.svh"

// =========================================================
// asynchronous elastic fifo
module elastic_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 64
) (
  // write side
  input  wire logic             wr_clk,
  input  wire logic             wr_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic [$clog2(DEPTH):0] wr_level,
  // read side
  input  wire logic             rd_clk,
  input  wire logic             rd_rst,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] rd_level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_LVL = (AW+1)'(DEPTH);

  function automatic logic [AW:0] b2g(input logic [AW:0] b);
    b2g = b ^ (b >> 1);
  endfunction : b2g

  function automatic logic [AW:0] g2b(input logic [AW:0] g);
    logic [AW:0] b;
    b     = '0;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    g2b = b;
  endfunction : g2b

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin_r, wbin_nxt, wgray_r, wgray_nxt;
  logic [AW:0] rbin_r, rbin_nxt, rgray_r, rgray_nxt;
  logic [AW:0] rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
  logic        in_ready_nxt;
  logic        push, pop;

  // =========================================================
  // write domain
  assign push     = in_valid && in_ready;
  assign wr_level = wbin_r - g2b(rg_s2_r);

  always_comb begin
    wbin_nxt     = wbin_r + (AW+1)'(push);
    wgray_nxt    = b2g(wbin_nxt);
    in_ready_nxt = (wbin_nxt - g2b(rg_s2_r)) != FULL_LVL;
    if (wr_rst) begin
      wbin_nxt     = '0;
      wgray_nxt    = '0;
      in_ready_nxt = 1'b0;
    end
  end

  always_ff @(posedge wr_clk) begin
    wbin_r   <= wbin_nxt;
    wgray_r  <= wgray_nxt;
    in_ready <= in_ready_nxt;
    rg_s1_r  <= wr_rst ? '0 : rgray_r;
    rg_s2_r  <= wr_rst ? '0 : rg_s1_r;
    if (push) begin
      mem[wbin_r[AW-1:0]] <= in_data;
    end
  end

  // =========================================================
  // read domain
  assign rd_level  = g2b(wg_s2_r) - rbin_r;
  assign out_valid = rd_level != '0;
  assign out_data  = mem[rbin_r[AW-1:0]];
  assign pop       = out_valid && out_ready;

  always_comb begin
    rbin_nxt  = rbin_r + (AW+1)'(pop);
    rgray_nxt = b2g(rbin_nxt);
    if (rd_rst) begin
      rbin_nxt  = '0;
      rgray_nxt = '0;
    end
  end

  always_ff @(posedge rd_clk) begin
    rbin_r  <= rbin_nxt;
    rgray_r <= rgray_nxt;
    wg_s1_r <= rd_rst ? '0 : wgray_r;
    wg_s2_r <= rd_rst ? '0 : wg_s1_r;
  end
endmodule : elastic_fifo

// =========================================================
// bridge top
module gmii_pcs_elastic_bridge (
  // main clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // link clock from pcs
  input  wire logic       pcs_clk,
  // control
  input  wire logic [1:0] mac_speed,
  input  wire logic       buf_soft_rst,
  // mac transmit
  input  wire logic [7:0] mac_txd,
  input  wire logic       mac_tx_en,
  input  wire logic       mac_tx_er,
  input  wire logic       mac_tx_valid,
  output logic            mac_tx_ready,
  // pcs transmit
  input  wire logic       pcs_tx_ena,
  output logic [7:0]      pcs_gmii_txd,
  output logic            pcs_gmii_tx_en,
  output logic            pcs_gmii_tx_er,
  output logic [3:0]      pcs_mii_txd,
  output logic            pcs_mii_tx_en,
  output logic            pcs_mii_tx_er,
  // pcs receive
  input  wire logic       pcs_rx_ena,
  input  wire logic [7:0] pcs_gmii_rxd,
  input  wire logic       pcs_gmii_rx_dv,
  input  wire logic       pcs_gmii_rx_er,
  input  wire logic [3:0] pcs_mii_rxd,
  input  wire logic       pcs_mii_rx_dv,
  input  wire logic       pcs_mii_rx_er,
  // mac receive
  output logic [7:0]      mac_rxd,
  output logic            mac_rx_dv,
  output logic            mac_rx_er,
  // clocks to mac
  output logic            mac_tx_clk,
  output logic            mac_rx_clk
);
  localparam logic [6:0] HI_LVL = 7'(`EB_HI_MARK);
  localparam logic [6:0] LO_LVL = 7'(`EB_LO_MARK);

  // =========================================================
  // synchronisers
  logic soft_s1_r, soft_m_r;
  logic lrst_s1_r, lrst_r, soft_ps1_r, soft_p_r;
  logic spd_s1_r;
  gmii_pcs_bridge_pkg::speed_mode_t mode_r;
  logic wr_rst, rd_rst;

  always_ff @(posedge mclk) begin
    soft_s1_r <= buf_soft_rst; // R13
    soft_m_r  <= soft_s1_r;
  end

  always_ff @(posedge pcs_clk) begin
    lrst_s1_r  <= srst; // R16
    lrst_r     <= lrst_s1_r;
    soft_ps1_r <= soft_m_r; // R16
    soft_p_r   <= soft_ps1_r;
    spd_s1_r   <= mac_speed[1]; // R8
    mode_r     <= gmii_pcs_bridge_pkg::speed_mode_t'(spd_s1_r);
  end

  assign wr_rst = srst || soft_m_r; // R13
  assign rd_rst = lrst_r || soft_p_r; // R17

  // =========================================================
  // write side: idle deletion
  logic                           in_idle, fifo_in_valid;
  logic [6:0]                     wr_level, rd_level;
  gmii_pcs_bridge_pkg::tx_word_t  in_word, out_word;
  logic                           fifo_out_valid, fifo_out_ready;

  assign in_word       = {mac_tx_er, mac_tx_en, mac_txd};
  assign in_idle       = !mac_tx_en && !mac_tx_er; // R12
  assign fifo_in_valid = mac_tx_valid && !(in_idle && wr_level >= HI_LVL); // R10

  elastic_fifo #(
    .WIDTH (`EB_WIDTH),
    .DEPTH (`EB_DEPTH)
  ) u_fifo (
    .wr_clk    (mclk),
    .wr_rst    (wr_rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (mac_tx_ready),
    .in_data   (in_word),
    .wr_level  (wr_level),
    .rd_clk    (pcs_clk),
    .rd_rst    (rd_rst),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (out_word),
    .rd_level  (rd_level)
  ); // R1 R4 R9

  // =========================================================
  // read side: idle insertion and pcs transmit
  logic                          slot, out_idle;
  gmii_pcs_bridge_pkg::tx_word_t tx_word;
  logic [9:0]                    gtx_r, gtx_nxt;
  logic [5:0]                    mtx_r, mtx_nxt;

  assign slot     = (mode_r == gmii_pcs_bridge_pkg::SPD_GMII) || pcs_tx_ena; // R7
  assign out_idle = !out_word[`TXW_EN] && !out_word[`TXW_ER]; // R12
  assign fifo_out_ready = slot && !rd_rst && !(out_idle && rd_level <= LO_LVL); // R11
  assign tx_word  = fifo_out_valid ? out_word : `TXW_IDLE; // R1

  always_comb begin
    gtx_nxt = gtx_r;
    mtx_nxt = mtx_r;
    if (rd_rst) begin
      gtx_nxt = `TXW_IDLE; // R17
      mtx_nxt = `MTXW_IDLE;
    end else if (slot) begin
      if (mode_r == gmii_pcs_bridge_pkg::SPD_GMII) begin
        gtx_nxt = tx_word;
        mtx_nxt = `MTXW_IDLE;
      end else begin
        gtx_nxt = `TXW_IDLE;
        mtx_nxt = {tx_word[`TXW_ER], tx_word[`TXW_EN], tx_word[3:0]};
      end
    end
  end

  always_ff @(posedge pcs_clk) begin
    gtx_r <= gtx_nxt;
    mtx_r <= mtx_nxt;
  end

  assign pcs_gmii_tx_er = gtx_r[9];
  assign pcs_gmii_tx_en = gtx_r[8];
  assign pcs_gmii_txd   = gtx_r[7:0];
  assign pcs_mii_tx_er  = mtx_r[5];
  assign pcs_mii_tx_en  = mtx_r[4];
  assign pcs_mii_txd    = mtx_r[3:0];

  // =========================================================
  // receive mux and gated clocks
  logic [9:0] rx_r, rx_nxt;
  logic       txc_r, txc_nxt, rxc_r, rxc_nxt;

  always_comb begin
    rx_nxt  = rx_r;
    txc_nxt = 1'b0;
    rxc_nxt = 1'b0;
    if (lrst_r) begin
      rx_nxt = {2'b00, `RXD_RST};
    end else if (mode_r == gmii_pcs_bridge_pkg::SPD_GMII) begin
      rx_nxt  = {pcs_gmii_rx_er, pcs_gmii_rx_dv, pcs_gmii_rxd}; // R3
      rxc_nxt = !rxc_r; // R6
    end else begin
      txc_nxt = pcs_tx_ena; // R5
      rxc_nxt = pcs_rx_ena; // R6
      if (pcs_rx_ena) begin
        rx_nxt = {pcs_mii_rx_er, pcs_mii_rx_dv, pcs_mii_rxd, pcs_mii_rxd}; // R2
      end
    end
  end

  always_ff @(posedge pcs_clk) begin
    rx_r  <= rx_nxt;
    txc_r <= txc_nxt;
    rxc_r <= rxc_nxt;
  end

  assign mac_rx_er  = rx_r[9];
  assign mac_rx_dv  = rx_r[8];
  assign mac_rxd    = rx_r[7:0];
  assign mac_tx_clk = txc_r;
  assign mac_rx_clk = rxc_r;

  // =========================================================
  // checks
  idle_drop_a : assert property (@(posedge mclk) disable iff (wr_rst) // R10
    (mac_tx_valid && in_idle && wr_level >= HI_LVL) |=> wr_level <= $past(wr_level))
    else $error("idle written above high mark");

  data_keep_a : assert property (@(posedge mclk) disable iff (wr_rst) // R12
    (mac_tx_valid && (mac_tx_en || mac_tx_er)) |-> fifo_in_valid)
    else $error("data word not offered to buffer");

  idle_hold_a : assert property (@(posedge pcs_clk) disable iff (rd_rst) // R11
    (fifo_out_valid && out_idle && rd_level <= LO_LVL) |-> !fifo_out_ready)
    else $error("idle advanced below low mark");

  mii_dup_a : assert property (@(posedge pcs_clk) disable iff (lrst_r) // R2
    (mode_r == gmii_pcs_bridge_pkg::SPD_MII && pcs_rx_ena)
    |=> mac_rxd == {2{$past(pcs_mii_rxd)}})
    else $error("mii nibble not duplicated");

  rx_mux_a : assert property (@(posedge pcs_clk) disable iff (lrst_r) // R3
    (mode_r == gmii_pcs_bridge_pkg::SPD_GMII) |=> mac_rxd == $past(pcs_gmii_rxd))
    else $error("gmii receive data not selected");

  soft_idle_a : assert property (@(posedge pcs_clk) // R17
    rd_rst |=> (!pcs_gmii_tx_en && !pcs_gmii_tx_er && !pcs_mii_tx_en && !pcs_mii_tx_er))
    else $error("transmit not idle in soft reset");

  empty_idle_a : assert property (@(posedge pcs_clk) disable iff (rd_rst) // R1
    (slot && !fifo_out_valid) |=> (!pcs_gmii_tx_en && !pcs_mii_tx_en))
    else $error("transmit enable without buffered data");

  txclk_gate_a : assert property (@(posedge pcs_clk) disable iff (lrst_r) // R5
    mac_tx_clk |-> ($past(pcs_tx_ena) && $past(mode_r) == gmii_pcs_bridge_pkg::SPD_MII)
                   ##1 !mac_tx_clk[*1])
    else $error("mac transmit clock not a gated pcs pulse");

  rxclk_mii_a : assert property (@(posedge pcs_clk) disable iff (lrst_r) // R6
    (mode_r == gmii_pcs_bridge_pkg::SPD_MII && $past(mode_r) == mode_r && !$past(lrst_r))
    |-> (mac_rx_clk == $past(pcs_rx_ena)))
    else $error("mac receive clock not following pcs enable");
endmodule : gmii_pcs_elastic_bridge

// [test/gmii_pcs_elastic_bridge_tb_top.sv]
`timescale 1ns/1ns
`include "gmii_pcs_bridge_cfg.svh"
module gmii_pcs_elastic_bridge_tb_top;
  logic       mclk, srst, pcs_clk, buf_soft_rst, stall, mac_tx_valid, mac_tx_ready;
  logic [1:0] mac_speed;
  logic [7:0] mac_txd, pcs_gmii_txd, pcs_gmii_rxd, mac_rxd;
  logic [3:0] pcs_mii_txd, pcs_mii_rxd;
  logic       mac_tx_en, mac_tx_er, pcs_tx_ena, pcs_rx_ena, mac_tx_clk, mac_rx_clk;
  logic       pcs_gmii_tx_en, pcs_gmii_tx_er, pcs_mii_tx_en, pcs_mii_tx_er;
  logic       pcs_gmii_rx_dv, pcs_gmii_rx_er, pcs_mii_rx_dv, pcs_mii_rx_er;
  logic       mac_rx_dv, mac_rx_er, p_et, p_er, p_rclk;
  logic [9:0] p_g;
  logic [5:0] p_m;
  int         fail_count = 0;
  int         checks = 0;
  bit         gmii, mon_on;
  gmii_pcs_bridge_pkg::tx_word_t exp_q[$], got_q[$];
  gmii_pcs_bridge_pkg::tx_word_t corner[3] = '{10'h100, 10'h200, 10'h3FF};

  gmii_pcs_elastic_bridge gmii_pcs_elastic_bridge_i (.*);
  pcs_partner pcs_partner_i (.pcs_clk(pcs_clk), .stall(stall), .tx_ena(pcs_tx_ena),
    .rx_ena(pcs_rx_ena), .g_rxd(pcs_gmii_rxd), .g_dv(pcs_gmii_rx_dv), .g_er(pcs_gmii_rx_er),
    .m_rxd(pcs_mii_rxd), .m_dv(pcs_mii_rx_dv), .m_er(pcs_mii_rx_er));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // in mii only the low nibble of the data byte travels
  function automatic gmii_pcs_bridge_pkg::tx_word_t expect_tx(
    input gmii_pcs_bridge_pkg::tx_word_t w, input bit g);
    return g ? w : (w & 10'h30F);
  endfunction : expect_tx

  // =========================================================
  // pcs side monitor
  always @(posedge pcs_clk) begin
    if (mon_on && gmii) begin
      check({mac_rx_er, mac_rx_dv, mac_rxd}, p_g);
      check({mac_tx_clk, mac_rx_clk}, {1'b0, !p_rclk});
      if (pcs_gmii_tx_en | pcs_gmii_tx_er)
        got_q.push_back({pcs_gmii_tx_er, pcs_gmii_tx_en, pcs_gmii_txd});
    end else if (mon_on) begin
      check({mac_tx_clk, mac_rx_clk}, {p_et, p_er});
      if (p_er) check({mac_rx_er, mac_rx_dv, mac_rxd}, {p_m, p_m[3:0]});
      if (p_et && (pcs_mii_tx_en | pcs_mii_tx_er))
        got_q.push_back({pcs_mii_tx_er, pcs_mii_tx_en, 4'h0, pcs_mii_txd});
    end
    p_g = {pcs_gmii_rx_er, pcs_gmii_rx_dv, pcs_gmii_rxd};
    p_m = {pcs_mii_rx_er, pcs_mii_rx_dv, pcs_mii_rxd};
    {p_et, p_er, p_rclk} = {pcs_tx_ena, pcs_rx_ena, mac_rx_clk};
  end

  // =========================================================
  // mac side driver and scenarios
  task automatic send(input gmii_pcs_bridge_pkg::tx_word_t w, input int lim, output bit ok);
    {mac_tx_er, mac_tx_en, mac_txd} = w;
    mac_tx_valid = 1'b1;
    ok = 1'b0;
    for (int n = 0; n < lim && !ok; n++) begin
      @(posedge mclk);
      ok = (mac_tx_ready === 1'b1);
      #1;
    end
  endtask : send

  task automatic run(input bit g);
    bit ok;
    int acc;
    gmii_pcs_bridge_pkg::tx_word_t w;
    mac_tx_valid = 1'b0;
    buf_soft_rst = 1'b1;
    mon_on = 1'b0;
    repeat (8) @(posedge mclk);
    check({pcs_gmii_txd, pcs_mii_txd, pcs_gmii_tx_en, pcs_gmii_tx_er,
           pcs_mii_tx_en, pcs_mii_tx_er, mac_tx_ready}, 0);
    #1 mac_speed = {g, 1'($urandom)};
    gmii = g;
    stall = !g;
    repeat (8) @(posedge mclk);
    #1 buf_soft_rst = 1'b0;
    repeat (6) @(posedge mclk);
    #1 {mon_on, ok, acc} = {1'b1, 1'b1, 0};
    exp_q.delete();
    got_q.delete();
    // read side stalled: fill until refused
    while (!g && ok && acc < 80) begin
      w = 10'($urandom) | 10'h100;
      send(w, 20, ok);
      if (ok) exp_q.push_back(expect_tx(w, g));
      if (ok) acc++;
    end
    if (!g) check(acc, `EB_DEPTH);
    stall = 1'b0;
    for (int i = 0; i < 100; i++) begin
      w = (i < 3) ? corner[i] : 10'($urandom);
      send(w, 50, ok);
      check(ok, 1'b1);
      if (w[9:8] != 2'b00) exp_q.push_back(expect_tx(w, g));
    end
    // keep idles flowing so the watermarks let the tail drain
    for (int n = 0; n < 3000 && got_q.size() < exp_q.size(); n++) send(10'h000, 50, ok);
    mac_tx_valid = 1'b0;
    check(got_q.size(), exp_q.size());
    foreach (exp_q[i]) if (i < got_q.size()) check(got_q[i], exp_q[i]);
  endtask : run

  task automatic finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  initial begin
    void'($urandom(32'h0AD3));
    {srst, buf_soft_rst, stall, gmii, mon_on} = 5'h1C;
    {mac_speed, mac_tx_valid, mac_tx_er, mac_tx_en, mac_txd} = '0;
    repeat (3) @(posedge mclk);
    #1 srst = 1'b0;
    run(1'b1);
    run(1'b0);
    finish_test;
  end
endmodule : gmii_pcs_elastic_bridge_tb_top

// [test/pcs_partner.sv]
`timescale 1ns/1ns
// =========================================================
// pcs side: link clock, nibble strobes, receive traffic
module pcs_partner (
  // link clock
  output logic       pcs_clk,
  // strobe hold-off
  input  wire logic  stall,
  // strobes
  output logic       tx_ena,
  output logic       rx_ena,
  // receive data
  output logic [7:0] g_rxd,
  output logic       g_dv,
  output logic       g_er,
  output logic [3:0] m_rxd,
  output logic       m_dv,
  output logic       m_er
);
  int n = 0;
  initial begin
    {pcs_clk, tx_ena, rx_ena, g_er, g_dv, g_rxd, m_er, m_dv, m_rxd} = '0;
    #7;
    forever #24 pcs_clk = ~pcs_clk;
  end
  // data changes every cycle so nothing stale can pass for a match
  always @(posedge pcs_clk) begin
    #1;
    n = n + 1;
    tx_ena = !stall && (n % 2 == 0);
    rx_ena = (n % 3 == 0);
    {g_er, g_dv, g_rxd} = 10'($urandom);
    {m_er, m_dv, m_rxd} = 6'($urandom);
  end
endmodule : pcs_partner
